// >>> inc/cmp_event_cfg.svh
`ifndef CMP_EVENT_CFG_SVH
`define CMP_EVENT_CFG_SVH
// Register index of the control and status register; byte address is four times it
`define CTRL_STATUS_ADDR   8'h97
// Register index of the mode and status register; byte address is four times it
`define MODE_STATUS_ADDR   8'h98
// Field positions of the control and status register
`define BIT_IDLE_RUN       5
`define BIT_EVENT_FLAG     4
`define BIT_ENABLE         3
`define BIT_COND_HI        2
// Field positions of the mode and status register
`define BIT_IRQ_ENABLE     0
`define BIT_IDLE_MODE      1
`define BIT_POWER_DOWN     2
`define BIT_RESULT         3
// Reset value of the condition select field
`define COND_RESET         3'h0
// Overflows to wait before a debounced resample
`define DEBOUNCE_OVF       2'h2
// AXI response codes
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// >>> inc/cmp_event_pkg.sv
package cmp_event_pkg;
   // Event condition select codes
   typedef enum logic [2:0] {
      COND_LOW      = 3'h0,
      COND_RISE     = 3'h1,
      COND_DB_TOG   = 3'h2,
      COND_DB_RISE  = 3'h3,
      COND_FALL     = 3'h4,
      COND_TOG      = 3'h5,
      COND_DB_FALL  = 3'h6,
      COND_HIGH     = 3'h7
   } cond_sel_e;
   // Debounce sequencer states, one-hot
   typedef enum logic [1:0] {
      DB_IDLE = 2'b01,
      DB_WAIT = 2'b10
   } db_state_e;
endpackage

// >>> verilog/comparator_event_logic.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_event_cfg.svh"
// Notes on behaviour
// - Result is one when plus exceeds minus
// - Comparator runs only with enable set
// - Disabled: result low, no flag events
// - Enabled: digital inputs of pins off
// - Flag set when selected condition met
// - Flag sticky until software clears it
// - Plain conditions sample every clock
// - Debounce ticks come from timer overflows
// - Debounce waits two overflows then resamples
// - Flag only if resample matches expectation
// - Debounced flag one to two periods later
// - Idle stops comparator unless idle-run set
// - Idle-run with interrupt enabled wakes CPU
// - Power-down always stops comparator
// - Interrupt request gated by enable bit zero of mode register
// - Register layout and zero reset
// - Condition codes map to eight modes
module comparator_event_logic
   import cmp_event_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        cmp_raw,
   input  wire logic        timer_overflow,
   input  wire logic        idle_mode,
   input  wire logic        power_down,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             cmp_irq,
   output logic             cpu_wake,
   output logic             digital_input_off,
   output logic             cmp_result
);

   // Condition match for a sampled and a previous value
   function automatic logic cond_hit(input cond_sel_e c, input logic cur, input logic prev);
      case (c)
         COND_LOW  : cond_hit = !cur;
         COND_HIGH : cond_hit = cur;
         COND_RISE : cond_hit = cur && !prev;
         COND_FALL : cond_hit = !cur && prev;
         COND_TOG  : cond_hit = cur != prev;
         default   : cond_hit = 1'b0;
      endcase
   endfunction

   // Transition that starts a debounce wait
   function automatic logic db_start(input cond_sel_e c, input logic cur, input logic prev);
      case (c)
         COND_DB_TOG  : db_start = cur != prev;
         COND_DB_RISE : db_start = cur && !prev;
         COND_DB_FALL : db_start = !cur && prev;
         default      : db_start = 1'b0;
      endcase
   endfunction

   logic        cmp_enable, cmp_idle_run, cmp_event_flag, irq_enable;
   logic [2:0]  event_condition_select, next_event_condition_select;
   logic        next_cmp_enable, next_cmp_idle_run, next_cmp_event_flag, next_irq_enable;
   logic        active, result_now, result_prev, next_result_prev;
   db_state_e   db_state, next_db_state;
   logic [1:0]  ovf_count, next_ovf_count;
   logic        expect_val, next_expect_val, event_hit, is_db;
   logic        aw_held, w_held, next_aw_held, next_w_held;
   logic [9:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data, next_rdata;
   logic [3:0]  w_strb, next_w_strb;
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic        do_write, wr_ctrl, wr_mode;
   logic        next_irq, next_wake, next_din_off, next_result;

   // Comparator is live only when enabled and not shut by a sleep mode
   assign active     = cmp_enable && !power_down && (!idle_mode || cmp_idle_run);
   assign result_now = active && cmp_raw;
   assign is_db      = event_condition_select == COND_DB_TOG || event_condition_select == COND_DB_RISE
                       || event_condition_select == COND_DB_FALL;

   // Debounce sequencer and event detection
   always_comb
   begin
      next_result_prev = result_now;
      next_db_state    = db_state;
      next_ovf_count   = ovf_count;
      next_expect_val  = expect_val;
      event_hit        = 1'b0;
      if (!active || !is_db)
      begin
         next_db_state  = DB_IDLE;
         next_ovf_count = 2'h0;
         if (active)
            event_hit = cond_hit(cond_sel_e'(event_condition_select), result_now, result_prev);
      end
      else
      begin
         case (db_state)
            DB_IDLE :
               if (db_start(cond_sel_e'(event_condition_select), result_now, result_prev))
               begin
                  next_db_state   = DB_WAIT;
                  next_ovf_count  = 2'h0;
                  next_expect_val = result_now;
               end
            DB_WAIT :
               if (timer_overflow)
               begin
                  next_ovf_count = ovf_count + 2'h1;
                  if (ovf_count + 2'h1 == `DEBOUNCE_OVF)
                  begin
                     next_db_state = DB_IDLE;
                     event_hit     = result_now == expect_val;
                  end
               end
            default :
               next_db_state = DB_IDLE;
         endcase
      end
   end

   // AXI write channel capture and register write
   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid && !s_axi_bready;
      next_bresp   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_held && w_held && !s_axi_bvalid;
      wr_ctrl  = do_write && aw_addr == {`CTRL_STATUS_ADDR, 2'b00} && w_strb[0];
      wr_mode  = do_write && aw_addr == {`MODE_STATUS_ADDR, 2'b00} && w_strb[0];
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (aw_addr == {`CTRL_STATUS_ADDR, 2'b00} || aw_addr == {`MODE_STATUS_ADDR, 2'b00})
                        ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   // Control bits and sticky flag; a hardware set beats a software clear
   always_comb
   begin
      next_cmp_enable             = cmp_enable;
      next_cmp_idle_run           = cmp_idle_run;
      next_event_condition_select = event_condition_select;
      next_cmp_event_flag         = cmp_event_flag;
      next_irq_enable             = irq_enable;
      if (wr_ctrl)
      begin
         next_cmp_idle_run           = w_data[`BIT_IDLE_RUN];
         next_cmp_enable             = w_data[`BIT_ENABLE];
         next_event_condition_select = w_data[`BIT_COND_HI:0];
         next_cmp_event_flag         = w_data[`BIT_EVENT_FLAG];
      end
      if (wr_mode)
         next_irq_enable = w_data[`BIT_IRQ_ENABLE];
      if (event_hit)
         next_cmp_event_flag = 1'b1;
   end

   // Read channel
   always_comb
   begin
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rdata  = 32'h0000_0000;
         next_rresp  = `RESP_OKAY;
         if (s_axi_araddr == {`CTRL_STATUS_ADDR, 2'b00})
         begin
            next_rdata[`BIT_IDLE_RUN]    = cmp_idle_run;
            next_rdata[`BIT_EVENT_FLAG]  = cmp_event_flag;
            next_rdata[`BIT_ENABLE]      = cmp_enable;
            next_rdata[`BIT_COND_HI:0]   = event_condition_select;
         end
         else if (s_axi_araddr == {`MODE_STATUS_ADDR, 2'b00})
         begin
            next_rdata[`BIT_IRQ_ENABLE] = irq_enable;
            next_rdata[`BIT_IDLE_MODE]  = idle_mode;
            next_rdata[`BIT_POWER_DOWN] = power_down;
            next_rdata[`BIT_RESULT]     = cmp_result;
         end
         else
            next_rresp = `RESP_SLVERR;
      end
   end

   // Output drives
   always_comb
   begin
      next_irq     = next_cmp_event_flag && next_irq_enable;
      next_wake    = next_irq && idle_mode && cmp_idle_run;
      next_din_off = next_cmp_enable;
      next_result  = result_now;
   end

   // State registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmp_enable             <= 1'b0;
         cmp_idle_run           <= 1'b0;
         cmp_event_flag         <= 1'b0;
         event_condition_select <= `COND_RESET;
         irq_enable             <= 1'b0;
         result_prev            <= 1'b0;
         db_state               <= DB_IDLE;
         ovf_count              <= 2'h0;
         expect_val             <= 1'b0;
         aw_held                <= 1'b0;
         w_held                 <= 1'b0;
         aw_addr                <= 10'h000;
         w_data                 <= 32'h0000_0000;
         w_strb                 <= 4'h0;
         s_axi_bvalid           <= 1'b0;
         s_axi_bresp            <= `RESP_OKAY;
         s_axi_rvalid           <= 1'b0;
         s_axi_rdata            <= 32'h0000_0000;
         s_axi_rresp            <= `RESP_OKAY;
         s_axi_awready          <= 1'b0;
         s_axi_wready           <= 1'b0;
         s_axi_arready          <= 1'b0;
         cmp_irq                <= 1'b0;
         cpu_wake               <= 1'b0;
         digital_input_off      <= 1'b0;
         cmp_result             <= 1'b0;
      end
      else
      begin
         cmp_enable             <= next_cmp_enable;
         cmp_idle_run           <= next_cmp_idle_run;
         cmp_event_flag         <= next_cmp_event_flag;
         event_condition_select <= next_event_condition_select;
         irq_enable             <= next_irq_enable;
         result_prev            <= next_result_prev;
         db_state               <= next_db_state;
         ovf_count              <= next_ovf_count;
         expect_val             <= next_expect_val;
         aw_held                <= next_aw_held;
         w_held                 <= next_w_held;
         aw_addr                <= next_aw_addr;
         w_data                 <= next_w_data;
         w_strb                 <= next_w_strb;
         s_axi_bvalid           <= next_bvalid;
         s_axi_bresp            <= next_bresp;
         s_axi_rvalid           <= next_rvalid;
         s_axi_rdata            <= next_rdata;
         s_axi_rresp            <= next_rresp;
         s_axi_awready          <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready           <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
         s_axi_arready          <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
         cmp_irq                <= next_irq;
         cpu_wake               <= next_wake;
         digital_input_off      <= next_din_off;
         cmp_result             <= next_result;
      end
   end

   // Named sequences for the debounce path
   sequence s_db_arm;
      db_state == DB_IDLE && active && is_db
         && db_start(cond_sel_e'(event_condition_select), result_now, result_prev);
   endsequence
   sequence s_db_wait;
      db_state == DB_WAIT;
   endsequence

   a_disabled_result_low : assert property (@(posedge clk) disable iff (!rst_b)
      !cmp_enable |=> !cmp_result) else $error("result not low while disabled");
   a_raw_result_pass : assert property (@(posedge clk) disable iff (!rst_b)
      active |=> cmp_result == $past(cmp_raw)) else $error("result does not follow comparison");
   a_power_down_off : assert property (@(posedge clk) disable iff (!rst_b)
      power_down |=> !cmp_result) else $error("result high in power-down");
   a_idle_stop : assert property (@(posedge clk) disable iff (!rst_b)
      idle_mode && !cmp_idle_run |=> !cmp_result) else $error("result high in idle without run");
   a_flag_sticky : assert property (@(posedge clk) disable iff (!rst_b)
      cmp_event_flag && !wr_ctrl |=> cmp_event_flag) else $error("flag cleared by hardware");
   a_no_event_disabled : assert property (@(posedge clk) disable iff (!rst_b)
      !cmp_event_flag && !cmp_enable && !wr_ctrl |=> !cmp_event_flag) else $error("flag set while disabled");
   a_high_level_set : assert property (@(posedge clk) disable iff (!rst_b)
      active && event_condition_select == COND_HIGH && cmp_raw |=> cmp_event_flag)
      else $error("high level did not set flag");
   a_rise_set : assert property (@(posedge clk) disable iff (!rst_b)
      active && event_condition_select == COND_RISE && result_now && !result_prev |=> cmp_event_flag)
      else $error("rising edge did not set flag");
   a_db_arm_wait : assert property (@(posedge clk) disable iff (!rst_b)
      s_db_arm ##1 (active && is_db) |-> s_db_wait) else $error("debounce did not start waiting");
   a_db_one_ovf : assert property (@(posedge clk) disable iff (!rst_b)
      s_db_wait and (ovf_count == 2'h0 && timer_overflow && active && is_db) |=> s_db_wait)
      else $error("debounce ended after one overflow");
   a_irq_gate : assert property (@(posedge clk) disable iff (!rst_b)
      cmp_irq |-> $past(next_irq_enable)) else $error("interrupt without enable");
   a_din_off : assert property (@(posedge clk) disable iff (!rst_b)
      cmp_enable |-> digital_input_off) else $error("digital input not disabled");

endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmp_event_cfg.svh"
module tb
   import cmp_event_pkg::*;
;
   typedef struct packed {cond_sel_e c; logic r0; logic r1; logic f;} row_s;
   logic        clk;
   logic        rst_b;
   logic        cmp_raw;
   logic        timer_overflow;
   logic        idle_mode;
   logic        power_down;
   logic [9:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [9:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        cmp_irq;
   logic        cpu_wake;
   logic        digital_input_off;
   logic        cmp_result;
   int          errors;
   int          tests_run;
   int          cycles;
   logic [31:0] d;
   logic [1:0]  r;
   // Start-up settling time, 10 us at 10 ns a cycle
   localparam int settle_cycles = 1000;
   // Plain conditions: raw before clearing, raw after, expected flag
   row_s rows [10] = '{'{COND_LOW, 1'b0, 1'b0, 1'b1}, '{COND_LOW, 1'b1, 1'b1, 1'b0},
      '{COND_HIGH, 1'b1, 1'b1, 1'b1}, '{COND_HIGH, 1'b0, 1'b0, 1'b0},
      '{COND_RISE, 1'b0, 1'b1, 1'b1}, '{COND_RISE, 1'b1, 1'b0, 1'b0},
      '{COND_FALL, 1'b1, 1'b0, 1'b1}, '{COND_FALL, 1'b0, 1'b1, 1'b0},
      '{COND_TOG, 1'b0, 1'b1, 1'b1}, '{COND_TOG, 1'b1, 1'b1, 1'b0}};

   comparator_event_logic dut_u (.clk, .rst_b, .cmp_raw, .timer_overflow, .idle_mode, .power_down,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_irq,
      .cpu_wake, .digital_input_off, .cmp_result);

   // Clock source, 10 ns period
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cuts a hang short
   initial
   begin
      cycles = 0;
      forever
      begin
         @(posedge clk);
         cycles++;
         if (cycles == 20000)
         begin
            errors++;
            complete_run();
         end
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chb(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask

   function automatic logic [31:0] ctrl(input logic ir, input logic en, input cond_sel_e c);
      return {26'h000_0000, ir, 1'b0, en, c};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw;
      logic w;
      @(posedge clk);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w)
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
            aw = 1'b0;
         if (s_axi_wready === 1'b1)
            w = 1'b0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      while (s_axi_bvalid !== 1'b1)
         @(posedge clk);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1)
         @(posedge clk);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic set_raw(input logic v);
      @(posedge clk);
      cmp_raw <= v;
   endtask

   task automatic pulse();
      @(posedge clk);
      timer_overflow <= 1'b1;
      @(posedge clk);
      timer_overflow <= 1'b0;
   endtask

   // Debounced transition, held or dropped back before the resample
   task automatic db_case(input cond_sel_e c, input logic r0, input logic keep);
      logic [31:0] v;
      logic [1:0]  rs;
      // Disable first so that no wait left from an earlier case carries over
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b0, c), rs);
      set_raw(r0);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, c), rs);
      set_raw(~r0);
      tick(3);
      pulse();
      tick(3);
      rd(`CTRL_STATUS_ADDR, v, rs);
      chb("debounce early flag", 1'b0, v[`BIT_EVENT_FLAG]);
      if (!keep)
         set_raw(r0);
      tick(3);
      pulse();
      tick(3);
      rd(`CTRL_STATUS_ADDR, v, rs);
      chb("debounce flag", keep, v[`BIT_EVENT_FLAG]);
   endtask

   // Main sequence
   initial
   begin
      errors = 0;
      tests_run = 0;
      rst_b = 1'b0;
      {cmp_raw, timer_overflow, idle_mode, power_down} = 4'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 10'h000;
      s_axi_araddr = 10'h000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h1;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      tick(2);
      rd(`CTRL_STATUS_ADDR, d, r);
      chk("control reset", 32'h0000_0000, d);
      rd(`MODE_STATUS_ADDR, d, r);
      chk("mode reset", 32'h0000_0000, d);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b1, 1'b1, COND_TOG), r);
      chk("write response", {30'h0, `RESP_OKAY}, {30'h0, r});
      tick(2);
      rd(`CTRL_STATUS_ADDR, d, r);
      chk("control fields", 32'h0000_002d, d);
      foreach (rows[i])
      begin
         set_raw(rows[i].r0);
         wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, rows[i].c), r);
         tick(4);
         wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, rows[i].c), r);
         set_raw(rows[i].r1);
         tick(4);
         rd(`CTRL_STATUS_ADDR, d, r);
         chb("event flag", rows[i].f, d[`BIT_EVENT_FLAG]);
         chb("result", rows[i].r1, cmp_result);
         chb("digital input off", 1'b1, digital_input_off);
      end
      // Flag stays after the cause has gone; request gated by enable
      set_raw(1'b0);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, COND_RISE), r);
      tick(4);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, COND_RISE), r);
      set_raw(1'b1);
      tick(3);
      set_raw(1'b0);
      tick(20);
      rd(`CTRL_STATUS_ADDR, d, r);
      chb("sticky flag", 1'b1, d[`BIT_EVENT_FLAG]);
      chb("masked request", 1'b0, cmp_irq);
      wr(`MODE_STATUS_ADDR, 32'h0000_0001, r);
      tick(3);
      chb("enabled request", 1'b1, cmp_irq);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, COND_RISE), r);
      tick(3);
      chb("request after clear", 1'b0, cmp_irq);
      // Disabled comparator holds result low and blocks events
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b0, COND_HIGH), r);
      set_raw(1'b1);
      tick(4);
      rd(`CTRL_STATUS_ADDR, d, r);
      chb("disabled flag", 1'b0, d[`BIT_EVENT_FLAG]);
      chb("disabled result", 1'b0, cmp_result);
      chb("disabled input off", 1'b0, digital_input_off);
      db_case(COND_DB_RISE, 1'b0, 1'b1);
      db_case(COND_DB_FALL, 1'b1, 1'b1);
      db_case(COND_DB_TOG, 1'b0, 1'b1);
      db_case(COND_DB_RISE, 1'b0, 1'b0);
      db_case(COND_DB_FALL, 1'b1, 1'b0);
      db_case(COND_DB_TOG, 1'b0, 1'b0);
      // Idle without and with idle-run, then power-down
      set_raw(1'b1);
      idle_mode <= 1'b1;
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, COND_HIGH), r);
      tick(4);
      rd(`CTRL_STATUS_ADDR, d, r);
      chb("idle flag", 1'b0, d[`BIT_EVENT_FLAG]);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b1, 1'b1, COND_HIGH), r);
      tick(4);
      rd(`CTRL_STATUS_ADDR, d, r);
      chb("idle-run flag", 1'b1, d[`BIT_EVENT_FLAG]);
      chb("wake", 1'b1, cpu_wake);
      @(posedge clk);
      power_down <= 1'b1;
      wr(`CTRL_STATUS_ADDR, ctrl(1'b1, 1'b1, COND_HIGH), r);
      tick(4);
      rd(`CTRL_STATUS_ADDR, d, r);
      chb("power-down flag", 1'b0, d[`BIT_EVENT_FLAG]);
      @(posedge clk);
      {idle_mode, power_down} <= 2'h0;
      // Start-up order: request off, enable, settle, clear the stale flag, request on
      wr(`MODE_STATUS_ADDR, 32'h0000_0000, r);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b0, COND_RISE), r);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, COND_RISE), r); // Pins taken as input-only already
      tick(settle_cycles);
      rd(`CTRL_STATUS_ADDR, d, r);
      chb("start-up flag", 1'b1, d[`BIT_EVENT_FLAG]);
      chb("start-up masked request", 1'b0, cmp_irq);
      wr(`CTRL_STATUS_ADDR, ctrl(1'b0, 1'b1, COND_RISE), r);
      wr(`MODE_STATUS_ADDR, 32'h0000_0001, r);
      tick(3);
      chb("start-up request", 1'b0, cmp_irq);
      // Unmapped place
      rd(8'h90, d, r);
      chk("unmapped read resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      chk("unmapped read data", 32'h0000_0000, d);
      wr(8'h90, 32'h0000_00ff, r);
      chk("unmapped write resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      complete_run();
   end
endmodule
`default_nettype wire
